// [rtl/ivp_cfg.svh]
// constants of the interrupt vector and priority resolver
// assumes inclusion by bare name from the package and the design modules
`ifndef IVP_CFG_SVH
`define IVP_CFG_SVH

// ==========================================================
// table geometry
`define IVP_VEC_COUNT      17
`define IVP_VEC_BITS       5
`define IVP_ADDR_BITS      21
`define IVP_ENTRY_WORDS    2
`define IVP_TARGET_BITS    19
`define IVP_BASE_RESET     21'h000000

// ==========================================================
// vector numbers
`define IVP_VEC_CHIP_RESET 5'h00
`define IVP_VEC_WDOG_RESET 5'h01
`define IVP_VEC_ILLEGAL    5'h02
`define IVP_VEC_SWI3       5'h03
`define IVP_VEC_STACK_OVF  5'h04
`define IVP_VEC_MISALIGN   5'h05
`define IVP_VEC_DBG_FIRST  5'h06
`define IVP_VEC_DBG_LAST   5'h0a
`define IVP_VEC_SWI2       5'h0b
`define IVP_VEC_SWI1       5'h0c
`define IVP_VEC_SWI0       5'h0d
`define IVP_VEC_RESERVED   5'h0e
`define IVP_VEC_LOW_VOLT   5'h0f
`define IVP_VEC_CLK_SYNTH  5'h10

// ==========================================================
// priority levels
`define IVP_LEVEL_0        2'h0
`define IVP_LEVEL_1        2'h1
`define IVP_LEVEL_2        2'h2
`define IVP_LEVEL_3        2'h3
`define IVP_PROG_COUNT     7

`endif

// [rtl/ivp_pkg.sv]
// types shared by the interrupt vector and priority resolver
// assumes ivp_cfg.svh on the include path
`include "ivp_cfg.svh"

package ivp_pkg;

    // ==========================================================
    // types
    typedef logic [1:0]                    level_type;
    typedef logic [`IVP_VEC_BITS-1:0]      vector_type;
    typedef logic [`IVP_ADDR_BITS-1:0]     address_type;

    typedef enum logic {
        ST_IDLE,
        ST_PRESENT
    } state_type;

endpackage

// [rtl/ivp_resolve.sv]
// combinational winner search over all pending vectors
// assumes per-vector levels already fixed or clamped by the caller
`timescale 1ns/100ps
`include "ivp_cfg.svh"

module ivp_resolve (
    input  wire logic [`IVP_VEC_COUNT-1:0]   pending,
    input  wire logic [2*`IVP_VEC_COUNT-1:0] levels,
    output logic                             found,
    output ivp_pkg::vector_type              winVector,
    output ivp_pkg::level_type               winLevel
);

    // ==========================================================
    // search
    // walk from the top vector down, taking equal levels too, so the
    // lowest vector wins a tie and a higher level always wins
    always_comb begin
        found     = 1'b0;
        winVector = `IVP_VEC_CHIP_RESET;
        winLevel  = `IVP_LEVEL_0;
        for (int i = `IVP_VEC_COUNT - 1; i >= 0; i--) begin
            if (pending[i] && (!found || levels[2*i +: 2] >= winLevel)) begin
                found     = 1'b1;
                winVector = ivp_pkg::vector_type'(i);
                winLevel  = levels[2*i +: 2];
            end
        end
    end

endmodule

// [rtl/ivp_controller.sv]
// interrupt vector and priority resolver facing the processor core
// assumes sources hold their request level until serviced and the core
// acknowledges each presented vector with a one-cycle pulse
`timescale 1ns/100ps
`include "ivp_cfg.svh"

module ivp_controller (
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire logic                          enable,
    input  wire logic [`IVP_VEC_COUNT-1:0]     irqPending,
    input  wire logic [2*`IVP_PROG_COUNT-1:0]  levelSetting,
    input  wire logic                          vectorTableBaseLoad,
    input  wire ivp_pkg::address_type          vectorTableBaseIn,
    input  wire logic                          vectorAck,
    output ivp_pkg::address_type               vectorTableBase,
    output ivp_pkg::address_type               chipResetAddress,
    output ivp_pkg::address_type               watchdogResetAddress,
    output logic                               vectorValid,
    output ivp_pkg::address_type               vectorAddress,
    output ivp_pkg::vector_type                vectorNumber,
    output ivp_pkg::level_type                 vectorLevel
);

    // ==========================================================
    // behaviour notes
    // - requests are levels, not pulses: a source that drops its line
    //   before the winner is captured simply loses its turn
    // - the search is purely combinational over seventeen entries, so
    //   the winner is ready in the same cycle that a request appears
    // - capture happens only from idle; a higher request arriving while
    //   a vector is presented waits until after the acknowledge, which
    //   keeps the presented address stable for the whole fetch
    // - one idle cycle follows every acknowledge, giving the serviced
    //   source a cycle to drop its line before the next search is taken
    // - a programmable slot written with 0 reads as level 1; level 0 is
    //   kept for the lowest software interrupt alone
    // - the two reset entries and the reserved entry never win, whatever
    //   their request bits show
    // - address arithmetic wraps at the program-space width; the reach
    //   limit of a table entry concerns its contents, not this block
    // - enable low freezes every register here, including the base, so
    //   a load strobe during a freeze is lost
    // - the reset-entry outputs follow the base register combinationally
    //   and so move one cycle after a load, together with the base
    // - the table contents themselves (jumps in the first two entries,
    //   calls elsewhere) are software's business and not checked here
    //
    // trade-off: no preemption of a presented vector keeps the core side
    // simple, at the cost of extra latency for a later, higher request,
    // which waits for the core's acknowledge and then one idle cycle

    // ==========================================================
    // per-vector level map
    logic [2*`IVP_VEC_COUNT-1:0] vecLevel;
    logic [`IVP_VEC_COUNT-1:0]   vecUsable;

    // slot k of levelSetting: k 0..4 debug unit, 5 low voltage, 6 clock synthesis
    genvar v;
    generate
        for (v = 0; v < `IVP_VEC_COUNT; v++) begin : g_vec
            localparam logic [`IVP_VEC_BITS-1:0] VN = `IVP_VEC_BITS'(v);
            localparam int SLOT = (v >= 15) ? v - 10 : v - 6;
            wire logic isProg = (VN >= `IVP_VEC_DBG_FIRST && VN <= `IVP_VEC_DBG_LAST)
                || VN == `IVP_VEC_LOW_VOLT || VN == `IVP_VEC_CLK_SYNTH;
            wire logic [1:0] rawLevel = isProg ? levelSetting[2*((SLOT < 0) ? 0 : SLOT) +: 2]
                                               : `IVP_LEVEL_0;
            // a written 0 would make the source unreachable above level 0, so clamp to 1
            wire logic [1:0] progLevel = (rawLevel == `IVP_LEVEL_0) ? `IVP_LEVEL_1 : rawLevel;
            wire logic [1:0] fixLevel =
                (VN >= `IVP_VEC_ILLEGAL && VN <= `IVP_VEC_MISALIGN) ? `IVP_LEVEL_3 :
                (VN == `IVP_VEC_SWI2) ? `IVP_LEVEL_2 :
                (VN == `IVP_VEC_SWI1) ? `IVP_LEVEL_1 : `IVP_LEVEL_0;
            assign vecLevel[2*v +: 2] = isProg ? progLevel : fixLevel;
            // reset entries are not interrupts; vector 14 has no source
            assign vecUsable[v] = VN != `IVP_VEC_CHIP_RESET && VN != `IVP_VEC_WDOG_RESET
                && VN != `IVP_VEC_RESERVED;
        end
    endgenerate

    // ==========================================================
    // winner search
    logic                winFound;
    ivp_pkg::vector_type winVector;
    ivp_pkg::level_type  winLevel;

    ivp_resolve u_resolve (
        .pending   (irqPending & vecUsable),
        .levels    (vecLevel),
        .found     (winFound),
        .winVector (winVector),
        .winLevel  (winLevel)
    );

    // ==========================================================
    // address forming
    // offset is two words per entry; 21-bit program space wraps on overflow
    // products are cut to the address width on purpose
    wire ivp_pkg::address_type winVectorWide;
    wire ivp_pkg::address_type winOffset;
    wire ivp_pkg::address_type winAddress;
    wire ivp_pkg::address_type wdogVectorWide;
    wire ivp_pkg::address_type wdogOffset;

    assign winVectorWide  = ivp_pkg::address_type'(winVector);
    assign winOffset      = ivp_pkg::address_type'(winVectorWide * `IVP_ENTRY_WORDS);
    assign winAddress     = ivp_pkg::address_type'(vectorTableBase + winOffset);
    assign wdogVectorWide = ivp_pkg::address_type'(`IVP_VEC_WDOG_RESET);
    assign wdogOffset     = ivp_pkg::address_type'(wdogVectorWide * `IVP_ENTRY_WORDS);

    // reset entries follow the base, so at its reset value they overlay the boot addresses
    assign chipResetAddress     = vectorTableBase;
    assign watchdogResetAddress = vectorTableBase + wdogOffset;

    // ==========================================================
    // base register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            vectorTableBase <= `IVP_BASE_RESET;
        end else if (enable && vectorTableBaseLoad) begin
            vectorTableBase <= vectorTableBaseIn;
        end
    end

    // ==========================================================
    // presentation handshake
    ivp_pkg::state_type state;
    ivp_pkg::state_type next_state;

    wire logic takeWinner = (state == ivp_pkg::ST_IDLE) && winFound;
    wire logic released   = (state == ivp_pkg::ST_PRESENT) && vectorAck;

    // one idle cycle after each acknowledge lets the source drop its request
    always_comb begin
        case (state)
            ivp_pkg::ST_IDLE:    next_state = winFound  ? ivp_pkg::ST_PRESENT : ivp_pkg::ST_IDLE;
            ivp_pkg::ST_PRESENT: next_state = vectorAck ? ivp_pkg::ST_IDLE : ivp_pkg::ST_PRESENT;
            default:             next_state = ivp_pkg::ST_IDLE;
        endcase
    end

    assign vectorValid = (state == ivp_pkg::ST_PRESENT);

    // state update, frozen with enable low
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= ivp_pkg::ST_IDLE;
        end else if (enable) begin
            state <= next_state;
        end
    end

    // captured winner; only loaded from idle so it cannot move while presented
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            vectorAddress <= `IVP_BASE_RESET;
            vectorNumber  <= `IVP_VEC_CHIP_RESET;
            vectorLevel   <= `IVP_LEVEL_0;
        end else if (enable && takeWinner) begin
            vectorAddress <= winAddress;
            vectorNumber  <= winVector;
            vectorLevel   <= winLevel;
        end
    end

endmodule

// [tb/ivp_controller_properties.sv]
// port checker of the vector resolver
// assumes binding onto ivp_controller, one clock domain
`timescale 1ns/100ps

module ivp_controller_properties (
    input wire logic                 clock,
    input wire logic                 rst_n,
    input wire logic                 enable,
    input wire logic                 vectorTableBaseLoad,
    input wire ivp_pkg::address_type vectorTableBaseIn,
    input wire logic                 vectorAck,
    input wire ivp_pkg::address_type vectorTableBase,
    input wire ivp_pkg::address_type chipResetAddress,
    input wire ivp_pkg::address_type watchdogResetAddress,
    input wire logic                 vectorValid,
    input wire ivp_pkg::address_type vectorAddress,
    input wire ivp_pkg::vector_type  vectorNumber,
    input wire ivp_pkg::level_type   vectorLevel
);
    // ========
    // relations between ports
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_base_load: assert property (enable && vectorTableBaseLoad |=> vectorTableBase == $past(vectorTableBaseIn))
        else $error("base not loaded");
    a_reset_entries: assert property (chipResetAddress == vectorTableBase && watchdogResetAddress == vectorTableBase + 21'h000002)
        else $error("reset entries off base");
    a_entry_offset: assert property ($rose(vectorValid) |-> vectorAddress == $past(vectorTableBase) + {15'h0000, vectorNumber, 1'b0})
        else $error("vector address wrong");
    a_hold_until_ack: assert property (vectorValid && !(vectorAck && enable) |=> vectorValid && $stable(vectorAddress) && $stable(vectorNumber))
        else $error("vector not held");
    a_ack_release: assert property (vectorValid && vectorAck && enable |=> !vectorValid)
        else $error("valid kept after ack");
    a_core_level: assert property (vectorValid && vectorNumber inside {[5'h02:5'h05]} |-> vectorLevel == 2'h3)
        else $error("core exception level");
    a_no_reserved: assert property (vectorValid |-> !(vectorNumber inside {5'h00, 5'h01, 5'h0e}))
        else $error("reserved vector presented");
    a_level_zero: assert property (vectorValid && vectorLevel == 2'h0 |-> vectorNumber == 5'h0d)
        else $error("level zero misused");
    // main scenarios reached
    cover property ($rose(vectorValid));
    cover property (vectorValid && vectorAck);
    cover property (enable && vectorTableBaseLoad);
endmodule

bind ivp_controller ivp_controller_properties i_chk (.*);

// [tb/ivp_core_model.sv]
// core side model acknowledging each presented vector
// assumes bench clock and reset; slow stretches each fetch
`timescale 1ns/100ps

module ivp_core_model (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic vectorValid,
    input  wire logic slow,
    output logic      vectorAck
);
    // ========
    // fetch timing
    int waitCount = 0;
    initial vectorAck = 1'b0;
    // fetches addresses only; table contents are software's affair
    // one-cycle pulse; never twice for one vector
    always @(posedge clock) begin
        waitCount <= (rst_n && vectorValid && !vectorAck) ? waitCount + 1 : 0;
        vectorAck <= #1 rst_n && vectorValid && !vectorAck && waitCount == (slow ? 3 : 0);
    end
endmodule

// [tb/tb_interrupt_vector_priority.sv]
// self-checking bench of the vector resolver
// assumes rtl/ on the include path and the core model
`timescale 1ns/100ps

module tb_interrupt_vector_priority;
    // ========
    // stimulus, design and core
    logic                 clock = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 enable = 1'b1;
    logic                 slow = 1'b0;
    logic [16:0]          irqPending = 17'h00000;
    logic [13:0]          levelSetting = 14'h0000;
    logic                 vectorTableBaseLoad = 1'b0;
    ivp_pkg::address_type vectorTableBaseIn = 21'h000000;
    ivp_pkg::address_type base = 21'h000000;
    logic                 vectorAck;
    logic                 vectorValid;
    ivp_pkg::address_type vectorTableBase;
    ivp_pkg::address_type chipResetAddress;
    ivp_pkg::address_type watchdogResetAddress;
    ivp_pkg::address_type vectorAddress;
    ivp_pkg::vector_type  vectorNumber;
    ivp_pkg::level_type   vectorLevel;
    int                   mismatches = 0;
    int                   check_count = 0;
    int                   cycles = 0;
    ivp_controller i_dut (.*);
    ivp_core_model i_core (.*);
    always #25 clock = ~clock;
    // hang guard, far above the few dozen cycles needed
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_of_test();
        end
    end
    // ========
    // shared tasks
    task automatic check(input ivp_pkg::address_type got, input ivp_pkg::address_type exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        if (mismatches == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // wait for a vector, judge it, drop its request once acknowledged
    task automatic serve(input ivp_pkg::vector_type n, input ivp_pkg::level_type lv);
        int k;
        k = 0;
        while (vectorValid !== 1'b1 && k < 20) begin
            @(posedge clock);
            #1 k++;
        end
        check({16'h0000, vectorNumber}, {16'h0000, n});
        check({19'h00000, vectorLevel}, {19'h00000, lv});
        check(vectorAddress, base + {15'h0000, n, 1'b0});
        // valid falls at the edge that takes the acknowledge; sampling it
        // a step later avoids racing the model's delayed pulse
        while (vectorValid === 1'b1 && k < 40) begin
            @(posedge clock);
            #1 k++;
        end
        check({20'h00000, vectorValid}, 21'h000000);
        irqPending[n] = 1'b0;
    endtask
    // ========
    // scenarios
    task automatic test_fixed;
        levelSetting = 14'h0002;
        irqPending = 17'h0784b;
        serve(5'h03, 2'h3);
        serve(5'h06, 2'h2);
        serve(5'h0b, 2'h2);
        serve(5'h0c, 2'h1);
        serve(5'h0d, 2'h0);
        repeat (3) @(posedge clock);
        check({20'h00000, vectorValid}, 21'h000000);
        #1 irqPending = 17'h00000;
    endtask
    task automatic test_programmable;
        levelSetting = 14'h3c04;
        irqPending = 17'h19180;
        serve(5'h0f, 2'h3);
        serve(5'h10, 2'h3);
        serve(5'h07, 2'h1);
        serve(5'h08, 2'h1);
        serve(5'h0c, 2'h1);
    endtask
    // moved base, frozen controller, then a slow core
    task automatic test_base;
        vectorTableBaseIn = 21'h004000;
        vectorTableBaseLoad = 1'b1;
        base = 21'h004000;
        @(posedge clock);
        #1 vectorTableBaseLoad = 1'b0;
        check(vectorTableBase, 21'h004000);
        check(chipResetAddress, 21'h004000);
        check(watchdogResetAddress, 21'h004002);
        enable = 1'b0;
        slow = 1'b1;
        irqPending = 17'h00030;
        repeat (3) @(posedge clock);
        check({20'h00000, vectorValid}, 21'h000000);
        #1 enable = 1'b1;
        serve(5'h04, 2'h3);
        serve(5'h05, 2'h3);
    endtask
    // ========
    // main sequence
    initial begin
        repeat (10) @(posedge clock);
        #1 rst_n = 1'b1;
        check(chipResetAddress, 21'h000000);
        check(watchdogResetAddress, 21'h000002);
        test_fixed();
        test_programmable();
        test_base();
        end_of_test();
    end
endmodule
